// ### rpe_defines.svh
// Constants for the reset pin and fifth port sharing block
`ifndef RPE_DEFINES_SVH
`define RPE_DEFINES_SVH
`define RPE_PORT_W 8
`define RPE_SHARED_BIT 3
`define RPE_CFG_EXT_RESET_PIN_BIT 7
`define RPE_ZERO_BYTE 8'h00
`define RPE_DIR_RESET 8'hFF
`define RPE_LAT_RESET 8'h00
`define RPE_OTHER_MASK 8'hF7
`endif

// ### rpe_pkg.sv
// Types for the reset pin and fifth port sharing block
`default_nettype none
`include "rpe_defines.svh"
package rpe_pkg;
	typedef logic [`RPE_PORT_W-1:0] rpe_byte_type;
	typedef enum logic [1:0] {RPE_SEL_DATA, RPE_SEL_DIR, RPE_SEL_LAT, RPE_SEL_NONE} rpe_sel_type;
	typedef enum {RPE_RUN, RPE_HELD} rpe_state_type;
endpackage
`default_nettype wire

// ### rpe_rd_if.sv
// Read path carrier between port core and read mux
`default_nettype none
interface rpe_rd_if;
	import rpe_pkg::*;
	rpe_byte_type pinVal;
	rpe_byte_type dirVal;
	rpe_byte_type latVal;
	logic wide;
	rpe_sel_type sel;
	rpe_byte_type data;
	modport core (output pinVal, dirVal, latVal, wide, sel, input data);
	modport mux (input pinVal, dirVal, latVal, wide, sel, output data);
endinterface
`default_nettype wire

// ### rpe_read_mux.sv
// Read data selection for the fifth port
`default_nettype none
`include "rpe_defines.svh"
module rpe_read_mux (
	rpe_rd_if.mux rd // Read path
);
	import rpe_pkg::*;
	always_comb begin
		rd.data = `RPE_ZERO_BYTE;
		if (!rd.wide) begin
			rd.data = `RPE_ZERO_BYTE;
		end else if (rd.sel == RPE_SEL_DATA) begin
			rd.data = rd.pinVal;
		end else if (rd.sel == RPE_SEL_DIR) begin
			rd.data = rd.dirVal;
		end else if (rd.sel == RPE_SEL_LAT) begin
			rd.data = rd.latVal;
		end
	end
endmodule
`default_nettype wire

// ### rpe_port.sv
// Reset pin and fifth port bit 3 sharing, top level
`default_nettype none
`include "rpe_defines.svh"
module rpe_port (
	input wire logic clk, // 200 MHz clock
	input wire logic rst_n, // Sync reset, active low
	input wire logic wideVariant, // High on 40-pin variant
	input wire rpe_pkg::rpe_byte_type configByteThreeHigh, // Configuration byte
	input wire logic extResetPin, // Shared reset pin level
	input wire logic progVoltage, // High voltage on shared pin
	input wire rpe_pkg::rpe_byte_type portPins, // Other port pin levels
	input wire logic dirWrite, // Direction register write strobe
	input wire logic latWrite, // Latch register write strobe
	input wire rpe_pkg::rpe_byte_type writeData, // Core write data
	input wire rpe_pkg::rpe_sel_type readSel, // Core read select
	output logic coreReset_n, // Core held in reset when low
	output logic progMode, // Programming entered
	output logic extResetEnable, // External reset active
	output var rpe_pkg::rpe_byte_type readData // Read value to core
);
	import rpe_pkg::*;
	rpe_rd_if rd ();
	rpe_byte_type dir_q, dir_d, lat_q, lat_d, rdata_q, rdata_d;
	rpe_state_type state_q, state_d;
	logic prog_q, prog_d, ext_reset_enable_q, ext_reset_enable_d;
	logic run_q, run_d, chkArm_q, chkArm_d;
	rpe_byte_type pinMix;

	// ****************************************
	// Helpers
	// ****************************************
	// Pin low with reset enabled and no programming voltage
	function automatic logic holdRequest(input logic enable, input logic pinLevel, input logic highVolt);
		return enable && !pinLevel && !highVolt;
	endfunction

	// Bit 3 is a live input only on the wide variant with reset off
	function automatic logic sharedLevel(input logic wide, input logic enable, input logic pinLevel);
		return wide && !enable && pinLevel;
	endfunction

	// ****************************************
	// Shared pin control
	// ****************************************
	always_comb begin
		ext_reset_enable_d = configByteThreeHigh[`RPE_CFG_EXT_RESET_PIN_BIT];
		prog_d = progVoltage;
		state_d = RPE_RUN;
		if (holdRequest(ext_reset_enable_d, extResetPin, progVoltage)) begin
			state_d = RPE_HELD;
		end
		run_d = (state_d == RPE_RUN);
		// Checks wait one cycle past reset release
		chkArm_d = rst_n;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ext_reset_enable_q <= 1'h0;
			prog_q <= 1'h0;
			state_q <= RPE_RUN;
			run_q <= 1'h1;
			chkArm_q <= 1'h0;
		end else begin
			ext_reset_enable_q <= ext_reset_enable_d;
			prog_q <= prog_d;
			state_q <= state_d;
			run_q <= run_d;
			chkArm_q <= chkArm_d;
		end
	end

	// ****************************************
	// Port registers
	// ****************************************
	always_comb begin
		dir_d = dir_q;
		lat_d = lat_q;
		if (!wideVariant) begin
			dir_d = `RPE_ZERO_BYTE;
			lat_d = `RPE_ZERO_BYTE;
		end else begin
			if (dirWrite) begin
				dir_d = writeData;
			end
			if (latWrite) begin
				lat_d = writeData;
			end
		end
		pinMix = portPins;
		pinMix[`RPE_SHARED_BIT] = sharedLevel(wideVariant, ext_reset_enable_q, extResetPin);
		rdata_d = rd.data;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dir_q <= `RPE_DIR_RESET;
			lat_q <= `RPE_LAT_RESET;
			rdata_q <= `RPE_ZERO_BYTE;
		end else begin
			dir_q <= dir_d;
			lat_q <= lat_d;
			rdata_q <= rdata_d;
		end
	end

	assign rd.pinVal = pinMix;
	assign rd.dirVal = dir_q;
	assign rd.latVal = lat_q;
	assign rd.wide = wideVariant;
	assign rd.sel = readSel;

	rpe_read_mux u_mux (
		.rd(rd)
	);

	assign coreReset_n = run_q;
	assign progMode = prog_q;
	assign extResetEnable = ext_reset_enable_q;
	assign readData = rdata_q;

	// ****************************************
	// Checks
	// ****************************************
	property p_narrowZero;
		@(posedge clk) disable iff (!rst_n || !chkArm_q)
			!wideVariant |=> readData == `RPE_ZERO_BYTE;
	endproperty
	a_narrowZero: assert property (p_narrowZero) else $error("28-pin read not zero");

	property p_narrowBit;
		@(posedge clk) disable iff (!rst_n || !chkArm_q)
			!wideVariant |=> !readData[`RPE_SHARED_BIT];
	endproperty
	a_narrowBit: assert property (p_narrowBit) else $error("28-pin bit 3 nonzero");

	property p_narrowInput;
		@(posedge clk) disable iff (!rst_n || !chkArm_q)
			(!wideVariant && !extResetEnable && readSel == RPE_SEL_DATA) |=> !readData[`RPE_SHARED_BIT];
	endproperty
	a_narrowInput: assert property (p_narrowInput) else $error("28-pin bit 3 acts as input");

	property p_bitInput;
		@(posedge clk) disable iff (!rst_n || !chkArm_q)
			(wideVariant && readSel == RPE_SEL_DATA && !ext_reset_enable_q) |=> readData[`RPE_SHARED_BIT] == $past(extResetPin);
	endproperty
	a_bitInput: assert property (p_bitInput) else $error("bit 3 not following pin");

	property p_otherBits;
		@(posedge clk) disable iff (!rst_n || !chkArm_q)
			(wideVariant && readSel == RPE_SEL_DATA) |=> (readData & `RPE_OTHER_MASK) == ($past(portPins) & `RPE_OTHER_MASK);
	endproperty
	a_otherBits: assert property (p_otherBits) else $error("port bits not following pins");

	property p_ext_reset_enable;
		@(posedge clk) disable iff (!rst_n || !chkArm_q)
			1'h1 |=> extResetEnable == $past(configByteThreeHigh[`RPE_CFG_EXT_RESET_PIN_BIT]);
	endproperty
	a_ext_reset_enable: assert property (p_ext_reset_enable) else $error("reset enable not tracking config");

	property p_noReset;
		@(posedge clk) disable iff (!rst_n || !chkArm_q)
			!configByteThreeHigh[`RPE_CFG_EXT_RESET_PIN_BIT] |=> coreReset_n;
	endproperty
	a_noReset: assert property (p_noReset) else $error("reset held while disabled");

	property p_prog;
		@(posedge clk) disable iff (!rst_n || !chkArm_q)
			progVoltage |=> progMode && coreReset_n;
	endproperty
	a_prog: assert property (p_prog) else $error("programming blocked");

	property p_dataZero;
		@(posedge clk) disable iff (!rst_n || !chkArm_q)
			(!wideVariant && readSel == RPE_SEL_DATA) |=> readData == `RPE_ZERO_BYTE;
	endproperty
	a_dataZero: assert property (p_dataZero) else $error("port data not zero");

	property p_unimpl;
		@(posedge clk) disable iff (!rst_n || !chkArm_q)
			(!wideVariant && readSel == RPE_SEL_NONE) |=> readData == `RPE_ZERO_BYTE;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented read nonzero");

	property p_dirLat;
		@(posedge clk) disable iff (!rst_n || !chkArm_q)
			!wideVariant [*2] |-> dir_q == `RPE_ZERO_BYTE && lat_q == `RPE_ZERO_BYTE;
	endproperty
	a_dirLat: assert property (p_dirLat) else $error("dir or latch not zero");

	property p_ignoreWrite;
		@(posedge clk) disable iff (!rst_n || !chkArm_q)
			(!wideVariant && (dirWrite || latWrite)) |=> dir_q == `RPE_ZERO_BYTE && lat_q == `RPE_ZERO_BYTE;
	endproperty
	a_ignoreWrite: assert property (p_ignoreWrite) else $error("28-pin write took effect");

	property p_dirRead;
		@(posedge clk) disable iff (!rst_n || !chkArm_q)
			(wideVariant && readSel == RPE_SEL_DIR) |=> readData == $past(dir_q);
	endproperty
	a_dirRead: assert property (p_dirRead) else $error("direction read wrong");

	property p_latRead;
		@(posedge clk) disable iff (!rst_n || !chkArm_q)
			(wideVariant && readSel == RPE_SEL_LAT) |=> readData == $past(lat_q);
	endproperty
	a_latRead: assert property (p_latRead) else $error("latch read wrong");

	property p_hold;
		@(posedge clk) disable iff (!rst_n || !chkArm_q)
			holdRequest(configByteThreeHigh[`RPE_CFG_EXT_RESET_PIN_BIT], extResetPin, progVoltage)
			|=> !coreReset_n && state_q == RPE_HELD;
	endproperty
	a_hold: assert property (p_hold) else $error("reset not held");

	property p_holdBit;
		@(posedge clk) disable iff (!rst_n || !chkArm_q)
			(wideVariant && extResetEnable && readSel == RPE_SEL_DATA) |=> !readData[`RPE_SHARED_BIT];
	endproperty
	a_holdBit: assert property (p_holdBit) else $error("bit 3 nonzero with reset enabled");
endmodule
`default_nettype wire

// ### rpe_reset_src.sv
// External reset circuit model driving the shared pin
`default_nettype none
module rpe_reset_src (
	input wire logic clk, // Clock
	input wire logic pullLow, // Request pin low
	input wire logic hiVolt, // Request programming voltage
	output logic extResetPin, // Shared pin level
	output logic progVoltage // Programming voltage present
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		extResetPin = 1'h1;
		progVoltage = 1'h0;
	end
	// Pulled up to supply unless driven low
	always @(posedge clk) begin
		extResetPin <= ~pullLow;
		progVoltage <= hiVolt;
	end
endmodule
`default_nettype wire

// ### test_rpe_port.sv
// Self-checking bench for the reset pin and fifth port block
`default_nettype none
module test_rpe_port;
	timeunit 1ns;
	timeprecision 1ps;
	import rpe_pkg::*;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic wide = 1'h1;
	logic dirWr = 1'h0;
	logic latWr = 1'h0;
	logic pullLow = 1'h0;
	logic hiVolt = 1'h0;
	logic pin, prog, resN, progM, extEn;
	rpe_byte_type cfg = 8'h00;
	rpe_byte_type pins = 8'h00;
	rpe_byte_type wData = 8'h00;
	rpe_byte_type rData;
	rpe_sel_type sel = RPE_SEL_DATA;
	int miscompares = 0;
	int n_checks = 0;
	int dirM = 8'hFF;
	int latM = 8'h00;
	rpe_reset_src u_src (.clk(clk), .pullLow(pullLow), .hiVolt(hiVolt), .extResetPin(pin), .progVoltage(prog));
	rpe_port u_dut (.clk(clk), .rst_n(rst_n), .wideVariant(wide), .configByteThreeHigh(cfg), .extResetPin(pin),
		.progVoltage(prog), .portPins(pins), .dirWrite(dirWr), .latWrite(latWr), .writeData(wData),
		.readSel(sel), .coreReset_n(resN), .progMode(progM), .extResetEnable(extEn), .readData(rData));
	initial begin
		forever #2.5 clk = ~clk;
	end
	// ****************
	// Tasks
	// ****************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		if (miscompares == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic toDir, input int v);
		@(posedge clk);
		dirWr <= toDir;
		latWr <= !toDir;
		wData <= v[7:0];
		@(posedge clk);
		dirWr <= 1'h0;
		latWr <= 1'h0;
		if (wide && toDir) dirM = v & 8'hFF;
		if (wide && !toDir) latM = v & 8'hFF;
	endtask
	task automatic apply(input int c, input int p, input logic low, input logic hv, input int s);
		int e;
		@(posedge clk);
		cfg <= c[7:0];
		pins <= p[7:0];
		pullLow <= low;
		hiVolt <= hv;
		sel <= rpe_sel_type'(s[1:0]);
		repeat (4) @(posedge clk);
		#1;
		case (s)
			0: e = (p & 8'hF7) | (((c >> 7) % 2 == 0 && !low) ? 8 : 0);
			1: e = dirM;
			2: e = latM;
			default: e = 0;
		endcase
		if (!wide) e = 0;
		chk({7'h00, extEn}, {7'h00, c[7]});
		chk({7'h00, resN}, {7'h00, !(c[7] && low && !hv)});
		chk({7'h00, progM}, {7'h00, hv});
		chk(rData, e[7:0]);
	endtask
	initial begin
		void'($urandom(32'h018cc045));
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		for (int i = 0; i < 80; i++) begin
			if (i == 40) begin
				@(posedge clk);
				rst_n <= 1'h0;
				wide <= 1'h0;
				repeat (2) @(posedge clk);
				rst_n <= 1'h1;
			end
			if ($urandom_range(2) == 0) wr($urandom_range(1), $urandom);
			apply($urandom, $urandom, $urandom_range(1), $urandom_range(3) == 0, i % 4);
		end
		stop_test();
	end
endmodule
`default_nettype wire
